// ---- logic/sbwrc_pkg.sv ----
// package: constants and types for the standby wake-up and reset control block
// Functional notes
// - nmi, unmasked ext or peripheral irq wakes
// - any of four resets ends standby
// - ordinary standby restores prior pll state
// - low-voltage standby keeps pll stopped
// - irq exit of ordinary standby: subclock mode
// - irq exit of low-voltage: low-voltage subclock
// - wake regardless of request priority
// - non-nested nmi acknowledged on release
// - globally disabled: maskable wake stays pending
// - equal or higher handler: request stays pending
// - lower-priority handler: acknowledge immediately
// - reset wake runs normal reset sequence
// - masked sources never end standby
// - fetch restarts at address zero
// - watchdog overflow and pin cause reset
// - low supply voltage causes reset
// - stopped main oscillation causes reset
// - record reset cause in flag register
// - pin reset clears flags, others set own
// - software writes zeros; set beats clear
package sbwrc_pkg;
   localparam int EXT_IRQ_N = 8;
   localparam int PRIO_W = 3;
   localparam int FLAGS_W = 8;
   // cause flag bit positions
   localparam int FLAG_LOWVOLT = 0;
   localparam int FLAG_CLOCKMON = 1;
   localparam int FLAG_WATCHDOG = 4;
   localparam logic [FLAGS_W-1:0] FLAGS_RESET = 8'h00;
   localparam logic [FLAGS_W-1:0] FLAGS_USED = 8'h13;
   localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
   // operating mode after release
   typedef enum logic [1:0] {
      SBWRC_MODE_RUN = 2'b00,
      SBWRC_MODE_SUB = 2'b01,
      SBWRC_MODE_LVSUB = 2'b10
   } sbwrc_mode_t;
   typedef enum logic [1:0] {
      SBWRC_ST_ACTIVE = 2'b00,
      SBWRC_ST_IDLE = 2'b01,
      SBWRC_ST_LVIDLE = 2'b10
   } sbwrc_state_t;
endpackage

// ---- logic/sbwrc_sync_if.sv ----
// interface: raw and synchronised wake request levels
`timescale 1ns/1ps
interface sbwrc_sync_if;
   logic [11:0] raw;
   logic [11:0] synced;
   modport src (output raw, input synced);
   modport snk (input raw, output synced);
endinterface

// ---- logic/sbwrc_sync.sv ----
// three-flop synchroniser for pin-level requests
`timescale 1ns/1ps
module sbwrc_sync (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // levels
   sbwrc_sync_if.snk port_sync
);
   logic [11:0] s1;
   logic [11:0] s2;
   logic [11:0] s3;
   logic [11:0] agreed;
   logic [11:0] next_agreed;
   // accept a change once stages two and three agree
   always_comb begin
      for (int i = 0; i < 12; i++) begin
         next_agreed[i] = (s2[i] == s3[i]) ? s3[i] : agreed[i];
      end
   end
   // register the chain
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s1 <= 12'h000;
         s2 <= 12'h000;
         s3 <= 12'h000;
         agreed <= 12'h000;
      end else begin
         s1 <= port_sync.raw;
         s2 <= s1;
         s3 <= s2;
         agreed <= next_agreed;
      end
   end
   assign port_sync.synced = agreed;
endmodule

// ---- logic/sbwrc_top.sv ----
// sub-idle wake-up decision, release mode and reset cause capture
`timescale 1ns/1ps
module sbwrc_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // reset sources
   input wire logic ext_reset_pin,
   input wire logic watchdog_reset_request,
   input wire logic lowvolt_reset_request,
   input wire logic clockmon_reset_request,
   // wake requests
   input wire logic pin_nmi_request,
   input wire logic watchdog_nmi_request,
   input wire logic [sbwrc_pkg::EXT_IRQ_N-1:0] ext_irq_lines,
   input wire logic [sbwrc_pkg::EXT_IRQ_N-1:0] ext_irq_unmasked,
   input wire logic periph_irq_request,
   input wire logic [sbwrc_pkg::PRIO_W-1:0] request_priority,
   // standby control bits
   input wire logic watchdog_nmi_wake_mask,
   input wire logic pin_nmi_wake_mask,
   input wire logic maskable_wake_mask,
   // cpu side
   input wire logic enter_idle,
   input wire logic enter_lvidle,
   input wire logic pll_running,
   input wire logic irq_globally_disabled,
   input wire logic in_handler,
   input wire logic in_nmi_handler,
   input wire logic [sbwrc_pkg::PRIO_W-1:0] handler_priority,
   input wire logic flags_write,
   input wire logic [sbwrc_pkg::FLAGS_W-1:0] flags_wdata,
   // status outputs
   output sbwrc_pkg::sbwrc_state_t standby_state,
   output sbwrc_pkg::sbwrc_mode_t op_mode,
   output logic pll_enable,
   output logic wake_release,
   output logic irq_ack,
   output logic irq_hold_pending,
   output logic system_reset,
   output logic [31:0] fetch_addr,
   output logic [sbwrc_pkg::FLAGS_W-1:0] reset_cause_flags
);
   import sbwrc_pkg::*;

   // pin and other-domain levels pass the synchroniser
   sbwrc_sync_if port_sync ();
   assign port_sync.raw = {pin_nmi_request, watchdog_nmi_request, ext_irq_lines,
                           periph_irq_request, ext_reset_pin};
   sbwrc_sync u_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .port_sync(port_sync)
   );
   logic s_pin_nmi;
   logic s_wdt_nmi;
   logic [EXT_IRQ_N-1:0] s_ext;
   logic s_periph;
   logic s_pin_rst;
   assign s_pin_nmi = port_sync.synced[11];
   assign s_wdt_nmi = port_sync.synced[10];
   assign s_ext = port_sync.synced[9:2];
   assign s_periph = port_sync.synced[1];
   assign s_pin_rst = port_sync.synced[0];

   // request qualification
   logic nmi_wake;
   logic mask_wake;
   logic any_reset;
   always_comb begin
      nmi_wake = (s_pin_nmi & ~pin_nmi_wake_mask)
               | (s_wdt_nmi & ~watchdog_nmi_wake_mask);
      mask_wake = ~maskable_wake_mask
                & ((|(s_ext & ext_irq_unmasked)) | s_periph);
      any_reset = s_pin_rst | watchdog_reset_request | lowvolt_reset_request
                | clockmon_reset_request;
   end

   // state and pll memory
   sbwrc_state_t state;
   sbwrc_state_t next_state;
   sbwrc_mode_t mode;
   sbwrc_mode_t next_mode;
   logic pll_saved;
   logic next_pll_saved;
   logic pll_en;
   logic next_pll_en;
   logic release_q;
   logic next_release;
   logic ack_q;
   logic next_ack;
   logic hold_q;
   logic next_hold;
   logic rst_q;
   logic next_rst;
   logic [31:0] fetch_q;
   logic [31:0] next_fetch;

   // wake decision: plain or of requests, no priority check
   always_comb begin
      next_state = state;
      next_mode = mode;
      next_pll_saved = pll_saved;
      next_pll_en = pll_en;
      next_release = 1'b0;
      next_ack = 1'b0;
      next_hold = hold_q & ~(state == SBWRC_ST_ACTIVE & ~irq_globally_disabled);
      next_rst = any_reset;
      next_fetch = fetch_q;
      if (any_reset) begin
         next_state = SBWRC_ST_ACTIVE;
         next_mode = SBWRC_MODE_RUN;
         next_pll_en = 1'b0;
         next_hold = 1'b0;
         next_release = (state != SBWRC_ST_ACTIVE);
         next_fetch = RESET_VECTOR;
      end else begin
         unique case (state)
            SBWRC_ST_ACTIVE: begin
               next_pll_en = pll_running;
               if (enter_lvidle) begin
                  next_state = SBWRC_ST_LVIDLE;
                  next_pll_saved = pll_running;
                  next_pll_en = 1'b0;
               end else if (enter_idle) begin
                  next_state = SBWRC_ST_IDLE;
                  next_pll_saved = pll_running;
                  next_pll_en = 1'b0;
               end
            end
            SBWRC_ST_IDLE, SBWRC_ST_LVIDLE: begin
               if (nmi_wake | mask_wake) begin
                  next_state = SBWRC_ST_ACTIVE;
                  next_release = 1'b1;
                  if (state == SBWRC_ST_IDLE) begin
                     next_mode = SBWRC_MODE_SUB;
                     next_pll_en = pll_saved;
                  end else begin
                     next_mode = SBWRC_MODE_LVSUB;
                     next_pll_en = 1'b0;
                  end
                  if (nmi_wake & ~in_nmi_handler) begin
                     next_ack = 1'b1;
                  end else if (irq_globally_disabled) begin
                     next_hold = 1'b1;
                  end else if (in_handler & (handler_priority <= request_priority)) begin
                     next_hold = 1'b1;
                  end else begin
                     next_ack = 1'b1;
                  end
               end
            end
            default: begin
               next_state = SBWRC_ST_ACTIVE;
            end
         endcase
      end
   end

   // register the wake state
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state <= SBWRC_ST_ACTIVE;
         mode <= SBWRC_MODE_RUN;
         pll_saved <= 1'b0;
         pll_en <= 1'b0;
         release_q <= 1'b0;
         ack_q <= 1'b0;
         hold_q <= 1'b0;
         rst_q <= 1'b0;
         fetch_q <= RESET_VECTOR;
      end else begin
         state <= next_state;
         mode <= next_mode;
         pll_saved <= next_pll_saved;
         pll_en <= next_pll_en;
         release_q <= next_release;
         ack_q <= next_ack;
         hold_q <= next_hold;
         rst_q <= next_rst;
         fetch_q <= next_fetch;
      end
   end

   // reset cause flags
   logic [FLAGS_W-1:0] flags;
   logic [FLAGS_W-1:0] next_flags;
   always_comb begin
      next_flags = flags;
      if (flags_write) begin
         next_flags = flags & flags_wdata & FLAGS_USED;
      end
      if (s_pin_rst) begin
         next_flags = FLAGS_RESET;
      end else begin
         if (watchdog_reset_request) next_flags[FLAG_WATCHDOG] = 1'b1;
         if (lowvolt_reset_request) next_flags[FLAG_LOWVOLT] = 1'b1;
         if (clockmon_reset_request) next_flags[FLAG_CLOCKMON] = 1'b1;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         flags <= FLAGS_RESET;
      end else begin
         flags <= next_flags;
      end
   end

   assign standby_state = state;
   assign op_mode = mode;
   assign pll_enable = pll_en;
   assign wake_release = release_q;
   assign irq_ack = ack_q;
   assign irq_hold_pending = hold_q;
   assign system_reset = rst_q;
   assign fetch_addr = fetch_q;
   assign reset_cause_flags = flags;

   // checks: standby entry, release mode and pll
   a_lvidle_pll_off: assert property (@(posedge clk_sys) disable iff (srst)
      state == SBWRC_ST_LVIDLE && !any_reset && (nmi_wake | mask_wake)
      |=> !pll_en && mode == SBWRC_MODE_LVSUB)
      else $error("pll not kept stopped after low-voltage release");
   a_idle_pll_restore: assert property (@(posedge clk_sys) disable iff (srst)
      state == SBWRC_ST_IDLE && !any_reset && (nmi_wake | mask_wake)
      |=> pll_en == $past(pll_saved) && mode == SBWRC_MODE_SUB)
      else $error("pll or mode wrong after idle release");
   a_entry_saves_pll: assert property (@(posedge clk_sys) disable iff (srst)
      state == SBWRC_ST_ACTIVE && !any_reset && (enter_idle || enter_lvidle)
      |=> pll_saved == $past(pll_running) && !pll_en)
      else $error("pll state not saved at standby entry");
   a_lv_entry_wins: assert property (@(posedge clk_sys) disable iff (srst)
      state == SBWRC_ST_ACTIVE && !any_reset && enter_lvidle
      |=> state == SBWRC_ST_LVIDLE)
      else $error("low-voltage standby not entered");
   // checks: wake sources and masks
   a_wake_one_cycle: assert property (@(posedge clk_sys) disable iff (srst)
      state != SBWRC_ST_ACTIVE && (nmi_wake | mask_wake)
      |=> state == SBWRC_ST_ACTIVE && release_q)
      else $error("standby not released");
   a_pin_nmi_wakes: assert property (@(posedge clk_sys) disable iff (srst)
      state != SBWRC_ST_ACTIVE && s_pin_nmi && !pin_nmi_wake_mask
      |=> state == SBWRC_ST_ACTIVE && release_q)
      else $error("pin nmi did not release standby");
   a_wdt_nmi_wakes: assert property (@(posedge clk_sys) disable iff (srst)
      state != SBWRC_ST_ACTIVE && s_wdt_nmi && !watchdog_nmi_wake_mask
      |=> state == SBWRC_ST_ACTIVE && release_q)
      else $error("watchdog nmi did not release standby");
   a_ext_irq_wakes: assert property (@(posedge clk_sys) disable iff (srst)
      state != SBWRC_ST_ACTIVE && (|(s_ext & ext_irq_unmasked)) && !maskable_wake_mask
      |=> state == SBWRC_ST_ACTIVE && release_q)
      else $error("external line did not release standby");
   a_periph_wakes: assert property (@(posedge clk_sys) disable iff (srst)
      state != SBWRC_ST_ACTIVE && s_periph && !maskable_wake_mask
      |=> state == SBWRC_ST_ACTIVE && release_q)
      else $error("peripheral request did not release standby");
   a_masked_no_wake: assert property (@(posedge clk_sys) disable iff (srst)
      state == SBWRC_ST_IDLE && !nmi_wake && !mask_wake && !any_reset
      |=> state == SBWRC_ST_IDLE)
      else $error("masked source released standby");
   a_nmi_mask_stays: assert property (@(posedge clk_sys) disable iff (srst)
      state != SBWRC_ST_ACTIVE && !any_reset && !s_periph && !(|(s_ext & ext_irq_unmasked))
      && (pin_nmi_wake_mask || !s_pin_nmi) && (watchdog_nmi_wake_mask || !s_wdt_nmi)
      |=> state == $past(state))
      else $error("masked nmi released standby");
   a_irq_mask_stays: assert property (@(posedge clk_sys) disable iff (srst)
      state != SBWRC_ST_ACTIVE && !any_reset && !s_pin_nmi && !s_wdt_nmi && maskable_wake_mask
      |=> state == $past(state))
      else $error("masked interrupt released standby");
   a_active_no_release: assert property (@(posedge clk_sys) disable iff (srst)
      state == SBWRC_ST_ACTIVE && !any_reset |=> !release_q)
      else $error("release pulse while active");
   a_release_pulse: assert property (@(posedge clk_sys) disable iff (srst)
      release_q |=> !release_q)
      else $error("release longer than one cycle");
   // checks: acknowledge or hold after release
   a_nmi_ack: assert property (@(posedge clk_sys) disable iff (srst)
      state != SBWRC_ST_ACTIVE && !any_reset && nmi_wake && !in_nmi_handler
      |=> ack_q && !hold_q)
      else $error("nmi not acknowledged");
   a_nmi_ignores_di: assert property (@(posedge clk_sys) disable iff (srst)
      state != SBWRC_ST_ACTIVE && !any_reset && nmi_wake && !in_nmi_handler
      && irq_globally_disabled |=> ack_q)
      else $error("nmi not acknowledged while disabled");
   a_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (srst)
      ack_q |=> !ack_q)
      else $error("acknowledge longer than one cycle");
   a_di_hold: assert property (@(posedge clk_sys) disable iff (srst)
      state != SBWRC_ST_ACTIVE && !any_reset && !nmi_wake && mask_wake
      && irq_globally_disabled |=> hold_q && !ack_q)
      else $error("disabled wake acknowledged");
   a_hold_clears: assert property (@(posedge clk_sys) disable iff (srst)
      hold_q && state == SBWRC_ST_ACTIVE && !irq_globally_disabled |=> !hold_q)
      else $error("pending hold not dropped once enabled");
   a_prio_hold: assert property (@(posedge clk_sys) disable iff (srst)
      state != SBWRC_ST_ACTIVE && !any_reset && !nmi_wake && mask_wake
      && !irq_globally_disabled && in_handler && handler_priority <= request_priority
      |=> hold_q && !ack_q)
      else $error("wake not held for busy handler");
   a_lower_prio_ack: assert property (@(posedge clk_sys) disable iff (srst)
      state != SBWRC_ST_ACTIVE && !any_reset && !nmi_wake && mask_wake && !irq_globally_disabled
      && !(in_handler && handler_priority <= request_priority) |=> ack_q && !hold_q)
      else $error("wake not acknowledged over lower handler");
   // checks: reset path
   a_reset_release: assert property (@(posedge clk_sys) disable iff (srst)
      any_reset |=> state == SBWRC_ST_ACTIVE && rst_q && fetch_q == RESET_VECTOR)
      else $error("reset did not restart");
   a_reset_no_ack: assert property (@(posedge clk_sys) disable iff (srst)
      any_reset |=> !ack_q && !hold_q && mode == SBWRC_MODE_RUN && !pll_en)
      else $error("reset release left interrupt state");
   a_sysreset_drops: assert property (@(posedge clk_sys) disable iff (srst)
      !any_reset |=> !rst_q)
      else $error("system reset without a source");
   // checks: reset cause flags
   a_flag_set_wins: assert property (@(posedge clk_sys) disable iff (srst)
      watchdog_reset_request && !s_pin_rst && flags_write
      |=> flags[FLAG_WATCHDOG])
      else $error("clear beat watchdog flag");
   a_clear_write: assert property (@(posedge clk_sys) disable iff (srst)
      flags_write && !s_pin_rst && !watchdog_reset_request && !lowvolt_reset_request
      && !clockmon_reset_request
      |=> flags == ($past(flags) & $past(flags_wdata) & FLAGS_USED))
      else $error("zero write did not clear flags");
   a_pin_clears: assert property (@(posedge clk_sys) disable iff (srst)
      s_pin_rst |=> flags == FLAGS_RESET)
      else $error("pin reset left flags");
   a_flags_keep: assert property (@(posedge clk_sys) disable iff (srst)
      !s_pin_rst && !flags_write |=> (flags & $past(flags)) == $past(flags))
      else $error("reset flag lost without clear");
   a_lv_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
      lowvolt_reset_request && !s_pin_rst |=> flags[FLAG_LOWVOLT])
      else $error("low-voltage flag not set");
   a_cm_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
      clockmon_reset_request && !s_pin_rst |=> flags[FLAG_CLOCKMON])
      else $error("clock monitor flag not set");
   a_flags_unused_zero: assert property (@(posedge clk_sys) disable iff (srst)
      (flags & ~FLAGS_USED) == 8'h00)
      else $error("unused flag bit set");
   c_idle_wake: cover property (@(posedge clk_sys) state == SBWRC_ST_IDLE ##1 release_q);
   c_lv_wake: cover property (@(posedge clk_sys) state == SBWRC_ST_LVIDLE ##1 release_q);
   c_hold: cover property (@(posedge clk_sys) hold_q);
   c_ack: cover property (@(posedge clk_sys) ack_q);
   c_wdt_flag: cover property (@(posedge clk_sys) flags[FLAG_WATCHDOG]);
endmodule

// ---- test/sbwrc_rst_src.sv ----
// reset source model: holds each fired source level for a fixed span
`timescale 1ns/1ps
module sbwrc_rst_src #(
   parameter int HOLD = 6
) (
   // clock
   input wire logic clk_sys,
   // one strobe per source: pin, watchdog, low voltage, clock monitor
   input wire logic [3:0] fire,
   // reset source levels
   output logic ext_reset_pin,
   output logic watchdog_reset_request,
   output logic lowvolt_reset_request,
   output logic clockmon_reset_request
);
   logic [3:0] cnt [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
   // count down the hold span of every source
   always @(posedge clk_sys) begin
      for (int k = 0; k < 4; k++) begin
         if (fire[k]) cnt[k] <= 4'(HOLD);
         else if (cnt[k] != 4'h0) cnt[k] <= cnt[k] - 4'h1;
      end
   end
   // levels stay high while the span runs
   assign ext_reset_pin = (cnt[0] != 4'h0);
   assign watchdog_reset_request = (cnt[1] != 4'h0);
   assign lowvolt_reset_request = (cnt[2] != 4'h0);
   assign clockmon_reset_request = (cnt[3] != 4'h0);
endmodule

// ---- test/sbwrc_top_tb.sv ----
// self-checking bench for the standby wake-up and reset control block
`timescale 1ns/1ps
module sbwrc_top_tb;
   import sbwrc_pkg::*;
   logic clk_sys = 0;
   logic srst = 1;
   logic [3:0] fire = 4'h0;
   logic ext_reset_pin, watchdog_reset_request, lowvolt_reset_request, clockmon_reset_request;
   logic pin_nmi_request = 0, watchdog_nmi_request = 0, periph_irq_request = 0;
   logic [7:0] ext_irq_lines = 8'h00, ext_irq_unmasked = 8'h00, flags_wdata = 8'h00;
   logic [2:0] request_priority = 3'h0, handler_priority = 3'h0;
   logic watchdog_nmi_wake_mask = 0, pin_nmi_wake_mask = 0, maskable_wake_mask = 0;
   logic enter_idle = 0, enter_lvidle = 0, pll_running = 0, irq_globally_disabled = 0;
   logic in_handler = 0, in_nmi_handler = 0, flags_write = 0;
   sbwrc_state_t standby_state;
   sbwrc_mode_t op_mode;
   logic pll_enable, wake_release, irq_ack, irq_hold_pending, system_reset;
   logic [31:0] fetch_addr, r;
   logic [7:0] reset_cause_flags;
   logic [9:0] notes[$];
   logic [9:0] note;
   int miscompares = 0, checks = 0, seed = 32'h8259, k;

   sbwrc_rst_src i_sbwrc_rst_src (.clk_sys(clk_sys), .fire(fire),
      .ext_reset_pin(ext_reset_pin), .watchdog_reset_request(watchdog_reset_request),
      .lowvolt_reset_request(lowvolt_reset_request),
      .clockmon_reset_request(clockmon_reset_request));
   sbwrc_top i_sbwrc_top (.clk_sys(clk_sys), .srst(srst), .ext_reset_pin(ext_reset_pin),
      .watchdog_reset_request(watchdog_reset_request),
      .lowvolt_reset_request(lowvolt_reset_request),
      .clockmon_reset_request(clockmon_reset_request), .pin_nmi_request(pin_nmi_request),
      .watchdog_nmi_request(watchdog_nmi_request), .ext_irq_lines(ext_irq_lines),
      .ext_irq_unmasked(ext_irq_unmasked), .periph_irq_request(periph_irq_request),
      .request_priority(request_priority), .watchdog_nmi_wake_mask(watchdog_nmi_wake_mask),
      .pin_nmi_wake_mask(pin_nmi_wake_mask), .maskable_wake_mask(maskable_wake_mask),
      .enter_idle(enter_idle), .enter_lvidle(enter_lvidle), .pll_running(pll_running),
      .irq_globally_disabled(irq_globally_disabled), .in_handler(in_handler),
      .in_nmi_handler(in_nmi_handler), .handler_priority(handler_priority),
      .flags_write(flags_write),
      .flags_wdata(flags_wdata), .standby_state(standby_state), .op_mode(op_mode),
      .pll_enable(pll_enable), .wake_release(wake_release), .irq_ack(irq_ack),
      .irq_hold_pending(irq_hold_pending), .system_reset(system_reset),
      .fetch_addr(fetch_addr), .reset_cause_flags(reset_cause_flags));

   // clock
   always #5 clk_sys = ~clk_sys;

   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // bounded wait for a release pulse or a system reset
   task automatic wait_for(bit rst);
      int n;
      for (n = 0; n < 16 && (rst ? system_reset : wake_release) !== 1'b1; n++) tick(1);
      if (n == 16) begin
         miscompares++;
         finish_test();
      end
   endtask

   // each release is compared against the oldest note, under its care mask
   always @(posedge clk_sys) begin
      #2;
      if (wake_release === 1'b1) begin
         if (notes.size() == 0) check("spare release", 1, 0);
         else begin
            note = notes.pop_front();
            check("release", {op_mode, pll_enable, irq_ack, irq_hold_pending} & note[9:5],
               note[4:0] & note[9:5]);
         end
      end
   end

   // enter standby, request from one source, masked first when asked
   task automatic wake_case(int src, bit lv, bit masked);
      logic hold;
      hold = (src > 1 || in_nmi_handler)
         && (irq_globally_disabled || (in_handler && handler_priority <= request_priority));
      if (lv) enter_lvidle = 1;
      else enter_idle = 1;
      tick(1);
      enter_lvidle = 0;
      enter_idle = 0;
      check("state", standby_state, lv ? SBWRC_ST_LVIDLE : SBWRC_ST_IDLE);
      notes.push_back({5'h1f, lv ? SBWRC_MODE_LVSUB : SBWRC_MODE_SUB, lv ? 1'b0 : pll_running,
         !hold, hold});
      k = r[10:8];
      // unmask word set once per step, masked line already cleared
      if (masked && src == 2) ext_irq_unmasked = r[31:24] & ~(8'h01 << k);
      else ext_irq_unmasked = r[31:24] | (8'h01 << k);
      case (src)
         0: begin pin_nmi_wake_mask = masked; pin_nmi_request = 1; end
         1: begin watchdog_nmi_wake_mask = masked; watchdog_nmi_request = 1; end
         2: begin ext_irq_lines[k] = 1; end
         default: begin maskable_wake_mask = masked; periph_irq_request = 1; end
      endcase
      if (masked) begin
         tick(8);
         check("masked stay", standby_state, lv ? SBWRC_ST_LVIDLE : SBWRC_ST_IDLE);
         {pin_nmi_wake_mask, watchdog_nmi_wake_mask, maskable_wake_mask} = 3'h0;
         ext_irq_unmasked[k] = 1;
      end
      wait_for(0);
      {pin_nmi_request, watchdog_nmi_request, periph_irq_request} = 3'h0;
      ext_irq_lines = 8'h00;
      irq_globally_disabled = 0;
      tick(6);
      check("awake", standby_state, SBWRC_ST_ACTIVE);
   endtask

   // reset from standby by one source, optional zero write while it is high
   task automatic reset_case(int src, logic [7:0] wr, logic [7:0] exp);
      enter_idle = 1;
      tick(1);
      enter_idle = 0;
      notes.push_back({5'h1f, 5'h00});
      fire[src] = 1;
      tick(1);
      fire = 4'h0;
      wait_for(1);
      flags_write = (wr != 8'hff);
      flags_wdata = wr;
      tick(1);
      flags_write = 0;
      tick(12);
      check("flags", reset_cause_flags, exp);
      check("fetch", fetch_addr, RESET_VECTOR);
      check("state", standby_state, SBWRC_ST_ACTIVE);
   endtask

   initial begin
      tick(6);
      srst = 0;
      tick(1);
      for (int i = 0; i < 48; i++) begin
         r = $random(seed);
         {pll_running, irq_globally_disabled, in_handler} = r[2:0];
         in_nmi_handler = r[14];
         request_priority = r[5:3];
         handler_priority = r[13:11];
         wake_case(i % 4, i[2], (i % 3) == 0);
      end
      reset_case(2, 8'hff, 8'h01);
      reset_case(3, 8'hff, 8'h03);
      reset_case(1, 8'h00, 8'h10);
      // zero write with no reset pending clears the watchdog flag
      flags_write = 1;
      flags_wdata = 8'hef;
      tick(1);
      flags_write = 0;
      check("flags clear", reset_cause_flags, 8'h00);
      reset_case(0, 8'hff, 8'h00);
      check("notes left", notes.size(), 0);
      finish_test();
   end
endmodule
